// [design/hbm_params.svh]
// Offsets, field positions, reset values and timing counts of the host bus memory manager
`ifndef HBM_PARAMS_SVH
`define HBM_PARAMS_SVH

// ****************************************
// APB register offsets (byte addresses)
// ****************************************
`define HBM_CTRL_OFS 8'h00
`define HBM_WAIT_OFS 8'h04
`define HBM_STAT_OFS 8'h08

// ****************************************
// Field positions
// ****************************************
`define HBM_CTRL_CPLX_BIT 0
`define HBM_CTRL_TRIG_BIT 1
`define HBM_WAIT_ROM_LSB 0
`define HBM_WAIT_ROM_MSB 1
`define HBM_WAIT_EEP_LSB 2
`define HBM_WAIT_EEP_MSB 4
`define HBM_STAT_BUSY_BIT 0
`define HBM_STAT_SYS_BIT 1
`define HBM_STAT_SEG_LSB 2
`define HBM_STAT_SEG_MSB 4

// ****************************************
// Reset values and limits
// ****************************************
`define HBM_CTRL_RST 2'h0
`define HBM_WAIT_RST 5'h0D
`define HBM_ROM_WS_MIN 2'h1
`define HBM_ROM_WS_MAX 2'h3
`define HBM_EEP_WS_MIN 3'h3
`define HBM_EEP_WS_MAX 3'h6
`define HBM_FIX_WS 3'h1
// Word address of the shared upper increment register inside the correlator segment
`define HBM_SHARED_INCR_UPPER_ADDR 18'h00100

// ****************************************
// Timing
// ****************************************
`define HBM_REF_PERIOD_NS 50
`define HBM_REC_REAL_NS 300
`define HBM_REC_CPLX_NS 314
`define HBM_FLASH_GAP_NS 25
`define HBM_REC_REAL_CYC ((`HBM_REC_REAL_NS + `HBM_REF_PERIOD_NS - 1) / `HBM_REF_PERIOD_NS)
`define HBM_REC_CPLX_CYC ((`HBM_REC_CPLX_NS + `HBM_REF_PERIOD_NS - 1) / `HBM_REF_PERIOD_NS)
`define HBM_FLASH_CYC ((`HBM_FLASH_GAP_NS + `HBM_REF_PERIOD_NS - 1) / `HBM_REF_PERIOD_NS)
// One wait state is one processor clock period, two reference cycles
`define HBM_WS_CYC 2

`endif

// [design/hbm_pkg.sv]
// Types shared by the host bus memory manager
package hbm_pkg;

  typedef enum logic [2:0] {
    HBM_SEG_ROM = 3'h0,
    HBM_SEG_RAM = 3'h1,
    HBM_SEG_CORR = 3'h2,
    HBM_SEG_PERI = 3'h3,
    HBM_SEG_EEP = 3'h4,
    HBM_SEG_SPARE = 3'h5,
    HBM_SEG_NONE6 = 3'h6,
    HBM_SEG_NONE7 = 3'h7
  } hbm_seg_t;

  // Processor side request, sampled in the address phase
  typedef struct packed {
    logic [22:0] addr;
    logic byte_word_flag;
    logic memory_request;
    logic read_write_flag;
  } hbm_cpu_t;

  // Memory control outputs, all active low
  typedef struct packed {
    logic rom_select;
    logic ram_select;
    logic eeprom_select;
    logic spare_select;
    logic memory_read_strobe;
    logic [3:0] byte_write_selects;
  } hbm_mem_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } hbm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hbm_apb_rsp_t;

endpackage

// [design/hbm_recovery.sv]
// Correlator write recovery down-counter
`timescale 1ns/1ps
`include "hbm_params.svh"
module hbm_recovery (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic start_i,
  input wire logic complex_mode_i,
  // Status
  output logic busy_o
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] load;

  // RULE_24: rounded-up window length
  assign load = complex_mode_i ? 4'(`HBM_REC_CPLX_CYC) : 4'(`HBM_REC_REAL_CYC);
  // RULE_05: preset at write strobe fall
  assign cnt_nxt = start_i ? load : ((cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 4'h0;
      busy_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_o <= (cnt_nxt != 4'h0);
    end
  end

  // Window must stay covered for its whole length
  chk_rec_window_held: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // RULE_24
    (start_i && !complex_mode_i) |=> busy_o [*6] ##1 (!busy_o || $past(start_i)))
    else $error("recovery window shorter than 300ns");
endmodule // hbm_recovery

// [design/hbm_host_bus.sv]
// Host bus front end: segment decode, wait states, correlator recovery spacing and debug abort
//
// Functional notes
// RULE_01: Host avoids correlator for recovery window after writes
// RULE_02: Only correlator writes need recovery spacing
// RULE_03: Shared upper increment write starts no recovery
// RULE_04: Upper write followed by lower increment write
// RULE_05: Write latched at strobe fall, loaded within window
// RULE_06: Isolated correlator write proceeds at once
// RULE_07: Isolated correlator read adds no later delay
// RULE_08: Read after write held past write cycle
// RULE_09: Second write ends after recovery window
// RULE_10: System mode spacing enforced internally
// RULE_11: Standard mode uses external down-counters
// RULE_12: Address bits 22:20 select memory segment
// RULE_13: Internal registers word only; RAM byte writes
// RULE_14: Byte flag and A1:0 give lane selects
// RULE_15: Processor clock, latch and bus enable generated
// RULE_16: Wait state is one processor clock period
// RULE_17: One wait state for support functions
// RULE_18: Correlator one wait, more for recovery
// RULE_19: ROM 1-3, EEPROM/spare 3-6 programmable waits
// RULE_20: Cycle after flash read stretched 25ns
// RULE_21: Trigger rising edge gives data abort
// RULE_22: Standard mode drives no memory selects
// RULE_23: Select pin low means system mode
// RULE_24: Recovery count rounded up from sample mode
`timescale 1ns/1ps
`include "hbm_params.svh"
module hbm_host_bus (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // APB register port
  input wire hbm_pkg::hbm_apb_req_t apb_req_i,
  output hbm_pkg::hbm_apb_rsp_t apb_rsp_o,
  // Processor bus
  input wire hbm_pkg::hbm_cpu_t cpu_i,
  output logic processor_clock_out_o,
  output logic proc_addr_latch_enable_o,
  output logic data_bus_enable_out_o,
  output logic fault_request_out_o,
  // Memories and correlator
  output hbm_pkg::hbm_mem_t mem_o,
  output logic corr_write_strobe_o,
  // Pins
  input wire logic arm_system_select_i,
  input wire logic multi_function_pin_i
);
  import hbm_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sel_sync_r;
  logic [2:0] trig_sync_r;
  logic sys_mode_r;
  logic trig_r;
  logic trig_prev_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_sync_r <= 3'h7;
      trig_sync_r <= 3'h0;
      sys_mode_r <= 1'b0;
      trig_r <= 1'b0;
      trig_prev_r <= 1'b0;
    end else begin
      sel_sync_r <= {sel_sync_r[1:0], arm_system_select_i};
      trig_sync_r <= {trig_sync_r[1:0], multi_function_pin_i};
      // RULE_23: low level selects system mode
      if (sel_sync_r[1] == sel_sync_r[2]) begin
        sys_mode_r <= !sel_sync_r[2];
      end
      if (trig_sync_r[1] == trig_sync_r[2]) begin
        trig_r <= trig_sync_r[2];
      end
      trig_prev_r <= trig_r;
    end
  end

  // ****************************************
  // APB registers
  // ****************************************
  logic [1:0] ctrl_r;
  logic [4:0] wait_r;
  logic rec_busy;
  logic [2:0] last_seg_r;
  logic apb_wr;
  logic apb_hit;
  logic [31:0] rd_mux;

  assign apb_hit = (apb_req_i.paddr == `HBM_CTRL_OFS) || (apb_req_i.paddr == `HBM_WAIT_OFS) ||
                   (apb_req_i.paddr == `HBM_STAT_OFS);
  assign apb_wr = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready && apb_req_i.pwrite;
  assign rd_mux = (apb_req_i.paddr == `HBM_CTRL_OFS) ? {30'h0, ctrl_r} :
                  (apb_req_i.paddr == `HBM_WAIT_OFS) ? {27'h0, wait_r} :
                  (apb_req_i.paddr == `HBM_STAT_OFS) ? {27'h0, last_seg_r, sys_mode_r, rec_busy} :
                  32'h0;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= `HBM_CTRL_RST;
      wait_r <= `HBM_WAIT_RST;
      apb_rsp_o <= '0;
    end else begin
      // Answer in the first access cycle
      apb_rsp_o.pready <= apb_req_i.psel && !apb_req_i.penable;
      apb_rsp_o.pslverr <= apb_req_i.psel && !apb_req_i.penable && !apb_hit;
      apb_rsp_o.prdata <= (apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite) ? rd_mux : 32'h0;
      if (apb_wr && apb_req_i.paddr == `HBM_CTRL_OFS) begin
        ctrl_r <= apb_req_i.pwdata[1:0];
      end
      if (apb_wr && apb_req_i.paddr == `HBM_WAIT_OFS) begin
        wait_r <= apb_req_i.pwdata[4:0];
      end
    end
  end

  // ****************************************
  // Wait state decode
  // ****************************************
  // RULE_19: out-of-range settings are clamped so a bad write cannot hang the bus
  function automatic logic [2:0] ws_clamp(input logic [2:0] v, input logic [2:0] lo, input logic [2:0] hi);
    ws_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // RULE_16: wait states counted in whole processor periods
  // RULE_17: support functions take one wait state
  // RULE_18: correlator base of one wait state
  function automatic logic [3:0] seg_wait(input logic [2:0] seg, input logic [4:0] cfg);
    logic [2:0] ws;
    ws = 3'h0;
    case (hbm_seg_t'(seg))
      HBM_SEG_ROM: ws = ws_clamp({1'b0, cfg[`HBM_WAIT_ROM_MSB:`HBM_WAIT_ROM_LSB]},
                                  {1'b0, `HBM_ROM_WS_MIN}, {1'b0, `HBM_ROM_WS_MAX});
      HBM_SEG_EEP, HBM_SEG_SPARE: ws = ws_clamp(cfg[`HBM_WAIT_EEP_MSB:`HBM_WAIT_EEP_LSB],
                                                `HBM_EEP_WS_MIN, `HBM_EEP_WS_MAX);
      HBM_SEG_CORR, HBM_SEG_PERI: ws = `HBM_FIX_WS;
      default: ws = 3'h0;
    endcase
    seg_wait = 4'(ws * `HBM_WS_CYC);
  endfunction

  // ****************************************
  // Processor cycle sequencer
  // ****************************************
  typedef enum logic [1:0] {ST_ADDR, ST_WAIT, ST_HIGH} hbm_state_t;
  hbm_state_t state_r;
  hbm_state_t state_nxt;
  logic [3:0] wcnt_r;
  logic [3:0] wcnt_nxt;
  hbm_cpu_t cur_r;
  logic act_r;
  logic stretch_r;
  logic stretch_nxt;
  logic rec_start;

  // RULE_12: segment from address bits 22:20
  wire [2:0] in_seg = cpu_i.addr[22:20];
  wire [2:0] cur_seg = cur_r.addr[22:20];
  wire in_act = !cpu_i.memory_request;
  wire in_corr = in_act && (in_seg == HBM_SEG_CORR);
  wire cur_corr = act_r && (cur_seg == HBM_SEG_CORR);
  wire cur_wr = act_r && cur_r.read_write_flag;
  wire cur_upper = (cur_r.addr[19:2] == `HBM_SHARED_INCR_UPPER_ADDR);
  // RULE_10: spacing handled here in system mode, no external logic
  wire corr_hold = rec_busy || rec_start;
  wire flash_rd = act_r && !cur_r.read_write_flag && sys_mode_r &&
                  ((cur_seg == HBM_SEG_ROM) || (cur_seg == HBM_SEG_EEP));
  wire [3:0] in_wait = in_act ? seg_wait(in_seg, wait_r) : 4'h0;
  wire [3:0] add_wait = 4'(stretch_r ? `HBM_FLASH_CYC : 0);

  always_comb begin
    state_nxt = state_r;
    wcnt_nxt = wcnt_r;
    stretch_nxt = stretch_r;
    case (state_r)
      ST_ADDR: begin
        // RULE_20: stretch the cycle after a flash read
        wcnt_nxt = in_wait + add_wait;
        stretch_nxt = 1'b0;
        // RULE_06: isolated correlator write needs no extra wait
        if ((in_wait + add_wait) != 4'h0 || (in_corr && corr_hold)) begin
          state_nxt = ST_WAIT;
        end else begin
          state_nxt = ST_HIGH;
        end
      end
      ST_WAIT: begin
        if (wcnt_r > 4'h1) begin
          wcnt_nxt = wcnt_r - 4'h1;
        // RULE_18: extra whole waits while recovery runs
        end else if (cur_corr && rec_busy) begin
          wcnt_nxt = 4'(`HBM_WS_CYC);
        end else begin
          wcnt_nxt = 4'h0;
          state_nxt = ST_HIGH;
        end
      end
      ST_HIGH: begin
        state_nxt = ST_ADDR;
        stretch_nxt = flash_rd;
      end
      default: begin
        state_nxt = ST_ADDR;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_ADDR;
      wcnt_r <= 4'h0;
      stretch_r <= 1'b0;
      cur_r <= '0;
      act_r <= 1'b0;
      last_seg_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      wcnt_r <= wcnt_nxt;
      stretch_r <= stretch_nxt;
      if (state_r == ST_ADDR) begin
        cur_r <= cpu_i;
        act_r <= in_act;
        if (in_act) begin
          last_seg_r <= in_seg;
        end
      end
    end
  end

  // ****************************************
  // Correlator write recovery
  // ****************************************
  // RULE_02: only correlator writes feed the counter
  wire corr_wr_now = (state_r == ST_HIGH) && cur_corr && cur_wr;
  // RULE_03: shared upper writes start no recovery
  logic upper_r;
  // RULE_07: reads never start recovery
  assign rec_start = corr_write_strobe_o && !corr_wr_now && !upper_r;

  hbm_recovery u_rec (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .start_i(rec_start),
    .complex_mode_i(ctrl_r[`HBM_CTRL_CPLX_BIT]),
    .busy_o(rec_busy)
  );

  // ****************************************
  // Output stage
  // ****************************************
  // RULE_14: one low lane for a byte, all four for a word
  // RULE_13: byte lanes only for external RAM
  wire ram_byte = !cur_r.byte_word_flag && (cur_seg == HBM_SEG_RAM);
  wire [3:0] lane_n = ram_byte ? ~(4'h1 << cur_r.addr[1:0]) : 4'h0;
  wire mem_phase = act_r && (state_r != ST_ADDR) && sys_mode_r;
  logic abort_cnt_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      processor_clock_out_o <= 1'b0;
      proc_addr_latch_enable_o <= 1'b0;
      data_bus_enable_out_o <= 1'b0;
      fault_request_out_o <= 1'b0;
      corr_write_strobe_o <= 1'b0;
      upper_r <= 1'b0;
      abort_cnt_r <= 1'b0;
      mem_o <= '1;
    end else begin
      // RULE_15: clock, latch enable and bus enable
      processor_clock_out_o <= (state_r == ST_HIGH);
      proc_addr_latch_enable_o <= (state_r == ST_ADDR);
      data_bus_enable_out_o <= mem_phase && cur_r.read_write_flag;
      corr_write_strobe_o <= corr_wr_now;
      upper_r <= corr_wr_now && cur_upper;
      // RULE_22: no selects in standard mode
      mem_o.rom_select <= !(mem_phase && cur_seg == HBM_SEG_ROM);
      mem_o.ram_select <= !(mem_phase && cur_seg == HBM_SEG_RAM);
      mem_o.eeprom_select <= !(mem_phase && cur_seg == HBM_SEG_EEP);
      mem_o.spare_select <= !(mem_phase && cur_seg == HBM_SEG_SPARE);
      mem_o.memory_read_strobe <= !(mem_phase && !cur_r.read_write_flag);
      mem_o.byte_write_selects <= (mem_phase && cur_r.read_write_flag && state_r == ST_HIGH) ? lane_n : 4'hF;
      // RULE_21: abort held for one full processor period
      if (sys_mode_r && ctrl_r[`HBM_CTRL_TRIG_BIT] && trig_r && !trig_prev_r) begin
        fault_request_out_o <= 1'b1;
        abort_cnt_r <= 1'b1;
      end else if (abort_cnt_r) begin
        abort_cnt_r <= 1'b0;
      end else begin
        fault_request_out_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_rom_seg_select: assert property ( // RULE_12
    (state_r == ST_HIGH && act_r && sys_mode_r && cur_seg == HBM_SEG_ROM) |=> !mem_o.rom_select)
    else $error("rom select missing");
  chk_std_no_select: assert property ( // RULE_22
    $past(!sys_mode_r) && $past(!sys_mode_r, 2) |-> (mem_o.rom_select && mem_o.ram_select &&
      mem_o.eeprom_select && mem_o.spare_select))
    else $error("select driven in standard mode");
  chk_word_lanes: assert property ( // RULE_13
    (state_r == ST_HIGH && cur_wr && sys_mode_r && cur_seg != HBM_SEG_RAM) |=> mem_o.byte_write_selects == 4'h0)
    else $error("non-RAM write not word wide");
  chk_byte_lane: assert property ( // RULE_14
    (state_r == ST_HIGH && cur_wr && sys_mode_r && ram_byte) |=> $countones(~mem_o.byte_write_selects) == 1)
    else $error("byte write lane count wrong");
  chk_rec_starts: assert property ( // RULE_05
    rec_start |=> rec_busy)
    else $error("recovery not started after write");
  chk_upper_no_rec: assert property ( // RULE_03
    (corr_write_strobe_o && !corr_wr_now && upper_r && !rec_busy) |=> !rec_busy)
    else $error("upper increment write started recovery");
  chk_corr_spacing: assert property ( // RULE_18
    (state_r == ST_HIGH && cur_corr) |-> !rec_busy && !rec_start)
    else $error("correlator access inside recovery");
  chk_periph_one_ws: assert property ( // RULE_17
    (state_r == ST_ADDR && in_act && in_seg == HBM_SEG_PERI && !stretch_r) |=>
      (state_r == ST_WAIT) [*2] ##1 (state_r == ST_HIGH))
    else $error("support access not one wait state");
  chk_flash_gap: assert property ( // RULE_20
    (state_r == ST_HIGH && flash_rd) |=> (state_r == ST_ADDR) ##1 (state_r == ST_WAIT))
    else $error("cycle after flash read not stretched");
  chk_abort_edge: assert property ( // RULE_21
    (sys_mode_r && ctrl_r[`HBM_CTRL_TRIG_BIT] && trig_r && !trig_prev_r) |=> fault_request_out_o [*2])
    else $error("trigger edge gave no abort");
  chk_read_no_rec: assert property ( // RULE_07
    (state_r == ST_HIGH && cur_corr && !cur_wr) |=> !rec_start ##1 !rec_busy)
    else $error("correlator read started recovery");
  chk_bus_enable: assert property ( // RULE_15
    (state_r == ST_HIGH && cur_wr && sys_mode_r) |=> data_bus_enable_out_o && processor_clock_out_o)
    else $error("write cycle without bus enable");
endmodule // hbm_host_bus

// [bench/hbm_cpu_model.sv]
// Processor model that issues bus cycles to the memory manager
`timescale 1ns/1ps
module hbm_cpu_model
  import hbm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Device side
  input wire logic ale_i,
  output hbm_pkg::hbm_cpu_t cpu_o
);
  hbm_cpu_t req_q[$];

  task automatic push(input hbm_cpu_t r);
    req_q.push_back(r);
  endtask

  // ****************************************
  // Request sequencing
  // ****************************************
  // hold each request until taken
  // No spacing of its own: in system mode the device must stretch the cycle
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cpu_o <= '{addr: 23'h100010, byte_word_flag: 1'b1, memory_request: 1'b1, read_write_flag: 1'b1};
    end else if (ale_i) begin
      if (req_q.size() > 0) begin
        cpu_o <= req_q.pop_front();
      end else begin
        // Idle lines show the inverse of the last address, width and direction, with the request held inactive
        cpu_o <= '{addr: ~cpu_o.addr, byte_word_flag: ~cpu_o.byte_word_flag, memory_request: 1'b1,
                   read_write_flag: ~cpu_o.read_write_flag};
      end
    end
  end
endmodule // hbm_cpu_model

// [bench/hbm_host_bus_test.sv]
// Self-checking bench for the host bus memory manager
`timescale 1ns/1ps
`include "hbm_params.svh"
module hbm_host_bus_test;
  import hbm_pkg::*;
  typedef struct {logic [3:0] sel; logic [3:0] bws; logic wr; int lo; int hi;} hbm_exp_t;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic arm_sys_sel_n = 1'b1;
  logic trig = 1'b0;
  hbm_apb_req_t apb_req = '0;
  hbm_apb_rsp_t apb_rsp;
  hbm_cpu_t cpu;
  hbm_mem_t mem;
  logic pclk, ale, dbe, fault, wstb;
  logic wstb_d = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  integer seed = 84880;
  int rec_cyc = 6;
  int per = 0;
  int since_fall = 0;
  bit gap_on = 1'b0;
  bit fell_once = 1'b0;
  bit cur_ok = 1'b0;
  bit bws_due = 1'b0;
  logic [32:0] apb_q[$];
  logic [32:0] msk_q[$];
  hbm_exp_t exp_q[$];
  hbm_exp_t cur;

  always #25 ref_clk_i = ~ref_clk_i;

  hbm_host_bus dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .apb_req_i(apb_req), .apb_rsp_o(apb_rsp),
    .cpu_i(cpu), .processor_clock_out_o(pclk), .proc_addr_latch_enable_o(ale), .data_bus_enable_out_o(dbe),
    .fault_request_out_o(fault), .mem_o(mem), .corr_write_strobe_o(wstb), .arm_system_select_i(arm_sys_sel_n),
    .multi_function_pin_i(trig));
  hbm_cpu_model cpu_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ale_i(ale), .cpu_o(cpu));

  // ****************************************
  // Compare tasks and output monitor
  // ****************************************
  task automatic cmp_val(input string nm, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_gap(input string nm, input int lo, input int hi, input int n);
    cmp_count++;
    if (n < lo || n > hi) begin
      fails++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask

  always @(posedge ref_clk_i) begin
    per <= per + 1;
    since_fall <= since_fall + 1;
    wstb_d <= wstb;
    if (apb_rsp.pready === 1'b1) begin
      if (apb_q.size() == 0) cmp_val("apb answer", 33'h0, 33'h1);
      else cmp_val("apb answer", apb_q.pop_front(), {apb_rsp.pslverr, apb_rsp.prdata} & msk_q.pop_front());
    end
    if (ale === 1'b1) begin
      if (cur_ok) cmp_gap("cycle period", cur.lo, cur.hi, per);
      per <= 1;
      cur_ok <= 1'b0;
      if (cpu.memory_request === 1'b0) begin
        if (exp_q.size() == 0) cmp_val("cycle", 33'h0, 33'h1);
        else begin
          cur = exp_q.pop_front();
          cur_ok <= 1'b1;
          bws_due = 1'b1;
        end
      end
    end
    // Selects, strobe and bus enable all stand in the cycle of the clock high output
    if (pclk === 1'b1 && bws_due) begin
      bws_due = 1'b0;
      cmp_val("lane selects", {29'h0, cur.bws}, {29'h0, mem.byte_write_selects});
      cmp_val("selects", {27'h0, cur.sel, cur.wr, cur.wr}, {27'h0, mem.rom_select, mem.ram_select,
        mem.eeprom_select, mem.spare_select, mem.memory_read_strobe, dbe});
    end
    if (wstb_d === 1'b1 && wstb === 1'b0) begin
      since_fall <= 1;
      if (gap_on && fell_once) cmp_gap("write spacing", rec_cyc, 99, since_fall);
      fell_once <= 1'b1;
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  // One idle edge before each setup, so psel is never assigned twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    @(posedge ref_clk_i);
    apb_q.push_back(e & m);
    msk_q.push_back(m);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge ref_clk_i);
    apb_req.penable <= 1'b1;
    do @(posedge ref_clk_i); while (apb_rsp.pready !== 1'b1);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h100000000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask

  task automatic cpu_req(input logic [2:0] seg, input logic [19:0] off, input logic bw, input logic w,
                         input int lo, input int hi);
    hbm_exp_t e;
    hbm_cpu_t r;
    r = '{addr: {seg, off}, byte_word_flag: bw, memory_request: 1'b0, read_write_flag: w};
    case (seg)
      3'h0: e.sel = 4'h7;
      3'h1: e.sel = 4'hB;
      3'h4: e.sel = 4'hD;
      3'h5: e.sel = 4'hE;
      default: e.sel = 4'hF;
    endcase
    // one lane only for a RAM byte write
    e.bws = !w ? 4'hF : (seg == 3'h1 && !bw) ? ~(4'h1 << off[1:0]) : 4'h0;
    e.wr = w;
    e.lo = lo;
    e.hi = hi;
    exp_q.push_back(e);
    cpu_u.push(r);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((cpu_u.req_q.size() > 0 || exp_q.size() > 0) && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    repeat (16) @(posedge ref_clk_i);
  endtask

  task automatic corr_burst(input int rc);
    rec_cyc = rc;
    fell_once = 1'b0;
    gap_on = 1'b1;
    repeat (3) cpu_req(3'h2, 20'h00200, 1'b1, 1'b1, 4, 40);
    drain();
    gap_on = 1'b0;
  endtask

  task automatic abort_chk(input logic en);
    int hi;
    hi = 0;
    trig <= 1'b1;
    repeat (16) begin
      @(posedge ref_clk_i);
      if (fault === 1'b1) hi++;
    end
    trig <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    cmp_val("abort cycles", en ? 33'h2 : 33'h0, {1'b0, 32'(hi)});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int rom_ws;
    int eep_ws;
    rom_ws = 1 + ($unsigned($random(seed)) % 3);
    eep_ws = 3 + ($unsigned($random(seed)) % 4);
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rd(`HBM_CTRL_OFS, 33'h0, 33'h1FFFFFFFF);
    rd(`HBM_WAIT_OFS, 33'h0000000D, 33'h1FFFFFFFF);
    rd(`HBM_STAT_OFS, 33'h0, 33'h1FFFFFFE3);
    rd(8'h0C, 33'h100000000, 33'h1FFFFFFFF);
    repeat (30) begin
      @(posedge ref_clk_i);
      cmp_val("memory lines", {24'h0, 9'h1FF}, {24'h0, mem});
    end
    wr(`HBM_WAIT_OFS, {27'h0, eep_ws[2:0], rom_ws[1:0]});
    rd(`HBM_WAIT_OFS, {28'h0, eep_ws[2:0], rom_ws[1:0]}, 33'h1FFFFFFFF);
    wr(`HBM_STAT_OFS, 32'hFFFFFFFF);
    rd(`HBM_STAT_OFS, 33'h0, 33'h1FFFFFFE3);
    wr(`HBM_CTRL_OFS, 32'h00000003);
    rd(`HBM_CTRL_OFS, 33'h3, 33'h1FFFFFFFF);
    wr(`HBM_CTRL_OFS, 32'h0);
    arm_sys_sel_n <= 1'b0;
    // Let the mode synchroniser settle before the first cycle is issued
    repeat (6) @(posedge ref_clk_i);
    for (int k = 0; k < 4; k++) cpu_req(3'h1, {18'($random(seed)), 2'(k)}, 1'b0, 1'b1, 2, 4);
    cpu_req(3'h1, 20'h00123, 1'b1, 1'b0, 2, 4);
    repeat (2) cpu_req(3'h0, 20'h00400, 1'b1, 1'b0, 2 + 2 * rom_ws, 4 + 2 * rom_ws);
    cpu_req(3'h4, 20'h00800, 1'b1, 1'b0, 2 + 2 * eep_ws, 4 + 2 * eep_ws);
    cpu_req(3'h5, 20'h00001, 1'b0, 1'b1, 2 + 2 * eep_ws, 4 + 2 * eep_ws);
    cpu_req(3'h6, 20'h00000, 1'b1, 1'b0, 2, 20);
    cpu_req(3'h3, 20'h00010, 1'b1, 1'b1, 4, 6);
    cpu_req(3'h2, 20'h00202, 1'b0, 1'b1, 4, 6);
    drain();
    rd(`HBM_STAT_OFS, 33'h2, 33'h100000002);
    // upper increment write is followed by a lower one
    cpu_req(3'h2, {`HBM_SHARED_INCR_UPPER_ADDR, 2'b00}, 1'b1, 1'b1, 4, 6);
    cpu_req(3'h2, 20'h00040, 1'b1, 1'b1, 4, 6);
    cpu_req(3'h2, 20'h00044, 1'b1, 1'b1, 4, 40);
    cpu_req(3'h2, 20'h00048, 1'b1, 1'b0, 5, 40);
    cpu_req(3'h2, 20'h0004C, 1'b1, 1'b0, 4, 6);
    drain();
    corr_burst(6);
    wr(`HBM_CTRL_OFS, 32'h00000001);
    corr_burst(7);
    wr(`HBM_CTRL_OFS, 32'h00000002);
    abort_chk(1'b1);
    wr(`HBM_CTRL_OFS, 32'h0);
    abort_chk(1'b0);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    give_verdict();
  end
endmodule // hbm_host_bus_test
